// file: logic/conditioner_pkg.sv
// Shared constants and types for the port traffic conditioner.
package conditioner_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFF      = 8'h00;
  localparam logic [7:0] RX_RATE_OFF   = 8'h04;
  localparam logic [7:0] TX_RATE_OFF   = 8'h08;
  localparam logic [7:0] STORM_THR_OFF = 8'h0C;
  localparam logic [7:0] RX_DROP_OFF   = 8'h10;
  localparam logic [7:0] STORM_DROP_OFF = 8'h14;
  localparam logic [7:0] LEVEL_OFF     = 8'h18;

  // ==========================================================================
  // Control register fields
  localparam int RX_UNLIM_BIT = 0;
  localparam int TX_UNLIM_BIT = 1;
  localparam int STORM_EN_BIT = 2;
  localparam int STORM_TYPE_LSB = 4;
  localparam int DEF_PRIO_LSB = 8;

  // ==========================================================================
  // Rates in kbps and their reset values
  localparam int RATE_W = 20;
  localparam logic [RATE_W-1:0] RX_RATE_MIN  = 20'd3500;
  localparam logic [RATE_W-1:0] TX_RATE_MIN  = 20'd64;
  localparam logic [RATE_W-1:0] STORM_MIN    = 20'd3500;
  localparam logic [RATE_W-1:0] RATE_MAX     = 20'd1000000;
  localparam logic [RATE_W-1:0] STORM_RESET  = 20'd3500;
  localparam logic [2:0]        PRIO_RESET   = 3'h0;

  // ==========================================================================
  // Token buckets: one refill per millisecond adds the kbps figure in bits.
  localparam int TOK_W = 24;
  localparam logic [TOK_W-1:0] FRAME_BITS_MAX = 24'd12144;
  localparam int CLK_PERIOD_NS = 25;
  localparam int REFILL_NS     = 1000000;
  localparam int REFILL_CYCLES = REFILL_NS / CLK_PERIOD_NS;
  localparam int LEN_W = 14;

  // ==========================================================================
  // Frame classes and storm selections
  typedef enum logic [1:0] {
    KIND_UNICAST = 2'b00,
    KIND_BCAST   = 2'b01,
    KIND_MCAST   = 2'b10,
    KIND_UNKNOWN = 2'b11
  } frame_kind_t;

  typedef enum logic [1:0] {
    STORM_B   = 2'b00,
    STORM_BM  = 2'b01,
    STORM_BMU = 2'b10
  } storm_type_t;

endpackage : conditioner_pkg

// file: logic/port_rate_storm_priority.sv
// Per-port rate limiting, storm control and default priority with register access.
// Operation
// - Ingress unlimited by default, no limit then
// - Ingress limit rate 3500 to 1000000 kbps
// - Egress unlimited by default, no limit then
// - Egress limit rate 64 to 1000000 kbps
// - Storm control polices flooded frame classes
// - Selector: bcast, bcast+mcast, or plus unknown
// - Storm control per port, disabled by default
// - Storm threshold 3500 to 1000000, default 3500
// - Untagged frames get the port default priority
// - Default priority 0 lowest to 7 highest
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Simple synchronous FIFO with valid/ready on both sides.
module frame_fifo #(
  parameter int DW    = 14,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [DW-1:0]              in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [DW-1:0]                   out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;

  // Storage is written only; no reset needed on the data array.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop)
      begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : frame_fifo

// ============================================================================
// Top level: one switch port.
module port_rate_storm_priority #(
  parameter int REFILL_CYC = conditioner_pkg::REFILL_CYCLES,
  parameter int EG_DEPTH   = 8
) (
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  input  wire logic                                  hsel,
  input  wire logic [31:0]                           haddr,
  input  wire logic [1:0]                            htrans,
  input  wire logic                                  hwrite,
  input  wire logic [2:0]                            hsize,
  input  wire logic [31:0]                           hwdata,
  input  wire logic                                  hready,
  output logic                                       hreadyout,
  output logic                                       hresp,
  output logic [31:0]                                hrdata,
  input  wire logic                                  rx_valid,
  output logic                                       rx_ready,
  input  wire logic [conditioner_pkg::LEN_W-1:0]     rx_len,
  input  wire conditioner_pkg::frame_kind_t          rx_kind,
  input  wire logic                                  rx_tagged,
  input  wire logic [2:0]                            rx_prio,
  output logic                                       fwd_valid,
  input  wire logic                                  fwd_ready,
  output logic [conditioner_pkg::LEN_W-1:0]          fwd_len,
  output logic [2:0]                                 fwd_prio,
  input  wire logic                                  eg_valid,
  output logic                                       eg_ready,
  input  wire logic [conditioner_pkg::LEN_W-1:0]     eg_len,
  output logic                                       tx_valid,
  input  wire logic                                  tx_ready,
  output logic [conditioner_pkg::LEN_W-1:0]          tx_len
);
  import conditioner_pkg::*;

  localparam int TCW = $clog2(REFILL_CYC);
  localparam int FLW = $clog2(EG_DEPTH) + 1;

  // Configuration and status state.
  logic              rx_unlim_q;
  logic              tx_unlim_q;
  logic              storm_en_q;
  storm_type_t       storm_type_q;
  logic [2:0]        def_prio_q;
  logic [RATE_W-1:0] rx_rate_q;
  logic [RATE_W-1:0] tx_rate_q;
  logic [RATE_W-1:0] storm_thr_q;
  logic [15:0]       rx_drop_q;
  logic [15:0]       storm_drop_q;

  // Bus phase capture.
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic              addr_ok;

  // Refill timing and buckets: 0 ingress, 1 storm, 2 egress.
  logic [TCW-1:0]    tick_cnt_q;
  logic              tick;
  logic [TOK_W-1:0]  rate_w [3];
  logic [TOK_W-1:0]  use_w  [3];
  logic [TOK_W-1:0]  tok_w  [3];

  // Stream path signals.
  logic [TOK_W-1:0]  rx_bits;
  logic [TOK_W-1:0]  eg_bits;
  logic              rx_take;
  logic              storm_sel;
  logic              lim_hit;
  logic              storm_hit;
  logic              rx_drop;
  logic              fifo_valid;
  logic              fifo_pop;
  logic              tx_ok;
  logic [LEN_W-1:0]  fifo_len;
  logic [FLW-1:0]    fifo_level;

  // Keeps a written rate inside its programmable range.
  function automatic logic [RATE_W-1:0] clamp_rate(
    input logic [31:0]       v,
    input logic [RATE_W-1:0] lo
  );
    if (v < 32'(lo))
    begin
      return lo;
    end
    else if (v > 32'(RATE_MAX))
    begin
      return RATE_MAX;
    end
    return v[RATE_W-1:0];
  endfunction : clamp_rate

  // ==========================================================================
  // AHB-Lite slave: zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];

  // Read data is latched at the address phase so it comes from a flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addr_ok && !hwrite)
    begin
      unique case (haddr[7:0])
        CTRL_OFF:       hrdata <= {21'h0, def_prio_q, 2'h0, storm_type_q,
                                   1'b0, storm_en_q, tx_unlim_q, rx_unlim_q};
        RX_RATE_OFF:    hrdata <= {12'h000, rx_rate_q};
        TX_RATE_OFF:    hrdata <= {12'h000, tx_rate_q};
        STORM_THR_OFF:  hrdata <= {12'h000, storm_thr_q};
        RX_DROP_OFF:    hrdata <= {16'h0000, rx_drop_q};
        STORM_DROP_OFF: hrdata <= {16'h0000, storm_drop_q};
        LEVEL_OFF:      hrdata <= 32'(fifo_level);
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Writes are remembered at the address phase and applied with hwdata.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Configuration registers; an unsupported storm type falls back to all.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_unlim_q   <= 1'b1;
      tx_unlim_q   <= 1'b1;
      storm_en_q   <= 1'b0;
      storm_type_q <= STORM_B;
      def_prio_q   <= PRIO_RESET;
      rx_rate_q    <= RX_RATE_MIN;
      tx_rate_q    <= TX_RATE_MIN;
      storm_thr_q  <= STORM_RESET;
    end
    else if (wr_pend_q)
    begin
      unique case (wr_addr_q)
        CTRL_OFF:
        begin
          rx_unlim_q <= hwdata[RX_UNLIM_BIT];
          tx_unlim_q <= hwdata[TX_UNLIM_BIT];
          storm_en_q <= hwdata[STORM_EN_BIT];
          storm_type_q <= (hwdata[STORM_TYPE_LSB+:2] == 2'h3) ? STORM_BMU
                          : storm_type_t'(hwdata[STORM_TYPE_LSB+:2]);
          def_prio_q <= hwdata[DEF_PRIO_LSB+:3];
        end
        RX_RATE_OFF:   rx_rate_q   <= clamp_rate(hwdata, RX_RATE_MIN);
        TX_RATE_OFF:   tx_rate_q   <= clamp_rate(hwdata, TX_RATE_MIN);
        STORM_THR_OFF: storm_thr_q <= clamp_rate(hwdata, STORM_MIN);
        default:       ;
      endcase
    end
  end

  // ==========================================================================
  // Millisecond refill tick, a one-cycle enable.
  assign tick = (tick_cnt_q == TCW'(REFILL_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_q <= '0;
    end
    else
    begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // A kbps figure equals bits per millisecond, so each tick adds the rate.
  assign rate_w[0] = TOK_W'(rx_rate_q);
  assign rate_w[1] = TOK_W'(storm_thr_q);
  assign rate_w[2] = TOK_W'(tx_rate_q);

  // One bucket per limiter; the cap allows one full frame above a tick.
  for (genvar g = 0; g < 3; g++)
  begin : g_bucket
    logic [TOK_W:0]   sum;
    logic [TOK_W:0]   cap;
    logic [TOK_W-1:0] tok_q;

    assign cap   = {1'b0, rate_w[g]} + {1'b0, FRAME_BITS_MAX};
    assign sum   = {1'b0, tok_q} - {1'b0, use_w[g]}
                   + (tick ? {1'b0, rate_w[g]} : '0);
    assign tok_w[g] = tok_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        tok_q <= '0;
      end
      else
      begin
        tok_q <= (sum > cap) ? cap[TOK_W-1:0] : sum[TOK_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Ingress policing: a frame is spent only if it is forwarded.
  assign rx_bits  = TOK_W'({rx_len, 3'b000});
  assign rx_ready = !fwd_valid || fwd_ready;
  assign rx_take  = rx_valid && rx_ready;

  always_comb
  begin
    unique case (storm_type_q)
      STORM_B:   storm_sel = (rx_kind == KIND_BCAST);
      STORM_BM:  storm_sel = (rx_kind == KIND_BCAST) || (rx_kind == KIND_MCAST);
      default:   storm_sel = (rx_kind != KIND_UNICAST);
    endcase
    storm_sel = storm_sel && storm_en_q;
  end

  assign lim_hit   = !rx_unlim_q && (tok_w[0] < rx_bits);
  assign storm_hit = storm_sel && (tok_w[1] < rx_bits);
  assign rx_drop   = lim_hit || storm_hit;
  assign use_w[0]  = (rx_take && !rx_drop && !rx_unlim_q) ? rx_bits : '0;
  assign use_w[1]  = (rx_take && !rx_drop && storm_sel) ? rx_bits : '0;

  // Forward register; an untagged frame takes the port's default priority.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fwd_valid <= 1'b0;
      fwd_len   <= '0;
      fwd_prio  <= 3'h0;
    end
    else if (rx_ready)
    begin
      fwd_valid <= rx_take && !rx_drop;
      if (rx_take && !rx_drop)
      begin
        fwd_len  <= rx_len;
        fwd_prio <= rx_tagged ? rx_prio : def_prio_q;
      end
    end
  end

  // Drop counters saturate rather than wrap so software sees a storm.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_drop_q    <= 16'h0000;
      storm_drop_q <= 16'h0000;
    end
    else if (rx_take)
    begin
      if (lim_hit && rx_drop_q != 16'hFFFF)
      begin
        rx_drop_q <= rx_drop_q + 16'h0001;
      end
      if (storm_hit && !lim_hit && storm_drop_q != 16'hFFFF)
      begin
        storm_drop_q <= storm_drop_q + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Egress: frames wait in the FIFO until the bucket covers them.
  frame_fifo #(
    .DW    (LEN_W),
    .DEPTH (EG_DEPTH)
  ) u_eg_fifo (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_valid  (eg_valid),
    .in_ready  (eg_ready),
    .in_data   (eg_len),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_len),
    .level     (fifo_level)
  );

  assign eg_bits  = TOK_W'({fifo_len, 3'b000});
  assign tx_ok    = tx_unlim_q || (tok_w[2] >= eg_bits);
  assign fifo_pop = fifo_valid && tx_ok && (!tx_valid || tx_ready);
  assign use_w[2] = (fifo_pop && !tx_unlim_q) ? eg_bits : '0;

  // Transmit register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_valid <= 1'b0;
      tx_len   <= '0;
    end
    else if (!tx_valid || tx_ready)
    begin
      tx_valid <= fifo_pop;
      if (fifo_pop)
      begin
        tx_len <= fifo_len;
      end
    end
  end
endmodule : port_rate_storm_priority

`default_nettype wire

// file: verif/prsp_assertions.sv
// Port-level assertions for the port traffic conditioner.
`timescale 1ns/100ps
`default_nettype none
module prsp_checker (
  input wire logic                              hclk,
  input wire logic                              hresetn,
  input wire logic                              hsel,
  input wire logic [1:0]                        htrans,
  input wire logic                              hwrite,
  input wire logic                              hready,
  input wire logic                              hreadyout,
  input wire logic                              hresp,
  input wire logic [31:0]                       hrdata,
  input wire logic                              rx_valid,
  input wire logic                              rx_ready,
  input wire logic [conditioner_pkg::LEN_W-1:0] rx_len,
  input wire logic                              rx_tagged,
  input wire logic [2:0]                        rx_prio,
  input wire logic                              fwd_valid,
  input wire logic                              fwd_ready,
  input wire logic [conditioner_pkg::LEN_W-1:0] fwd_len,
  input wire logic [2:0]                        fwd_prio,
  input wire logic                              eg_ready,
  input wire logic                              tx_valid,
  input wire logic                              tx_ready,
  input wire logic [conditioner_pkg::LEN_W-1:0] tx_len
);
  // ==========================================================================
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready okay");
  property p_rdy; rx_ready == (!fwd_valid || fwd_ready); endproperty
  a_rdy: assert property (p_rdy) else $error("ingress ready wrong");
  property p_fhold; fwd_valid && !fwd_ready |=> fwd_valid && $stable({fwd_len, fwd_prio});
  endproperty
  a_fhold: assert property (p_fhold) else $error("forward dropped while stalled");
  property p_thold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_len); endproperty
  a_thold: assert property (p_thold) else $error("egress dropped while stalled");
  property p_len; rx_valid && rx_ready |=> !fwd_valid || fwd_len == $past(rx_len); endproperty
  a_len: assert property (p_len) else $error("forward length wrong");
  property p_tag;
    rx_valid && rx_ready && rx_tagged |=> !fwd_valid || fwd_prio == $past(rx_prio);
  endproperty
  a_tag: assert property (p_tag) else $error("tagged priority changed");
  property p_src; $rose(fwd_valid) |-> $past(rx_valid && rx_ready); endproperty
  a_src: assert property (p_src) else $error("forward without ingress");
  property p_egr; $rose(eg_ready) |-> $past(tx_valid && tx_ready); endproperty
  a_egr: assert property (p_egr) else $error("egress space without departure");
  property p_rd; $changed(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite); endproperty
  a_rd: assert property (p_rd) else $error("read data moved without read");
  c_fwd: cover property (fwd_valid && fwd_ready);
  c_tx: cover property (tx_valid && tx_ready);
  c_full: cover property (!eg_ready);
endmodule : prsp_checker
bind port_rate_storm_priority prsp_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .rx_valid, .rx_ready, .rx_len, .rx_tagged, .rx_prio,
  .fwd_valid, .fwd_ready, .fwd_len, .fwd_prio, .eg_ready, .tx_valid, .tx_ready, .tx_len);
`default_nettype wire

// file: verif/fabric_model.sv
// Forwarding fabric and link model that accepts descriptors from the port.
`timescale 1ns/100ps
`default_nettype none
module fabric_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [1:0] mode,
  output logic           fwd_ready,
  output logic           tx_ready
);
  int seed = 32'h21564639;
  // Mode 0 takes at once, 1 stalls at random, 2 blocks the link to fill the queue.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) {fwd_ready, tx_ready} <= 2'h0;
    else if (mode == 2'h0) {fwd_ready, tx_ready} <= 2'h3;
    else if (mode == 2'h1) {fwd_ready, tx_ready} <= 2'($random(seed));
    else {fwd_ready, tx_ready} <= 2'h2;
  end
endmodule : fabric_model
`default_nettype wire

// file: verif/port_rate_storm_priority_tb_top.sv
// Self-checking bench for the port traffic conditioner.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module port_rate_storm_priority_tb_top;
  import conditioner_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rx_valid, rx_ready, rx_tagged;
  logic fwd_valid, fwd_ready, eg_valid, eg_ready, tx_valid, tx_ready, rph, pc, used;
  logic [31:0] haddr, hwdata, hrdata, er;
  logic [1:0] htrans, pmode;
  logic [2:0] hsize, rx_prio, fwd_prio, dp;
  logic [LEN_W-1:0] rx_len, fwd_len, eg_len, tx_len, et;
  frame_kind_t rx_kind;
  frame_kind_t ks[7] = '{KIND_UNICAST, KIND_BCAST, KIND_BCAST, KIND_MCAST, KIND_MCAST,
                         KIND_UNKNOWN, KIND_UNKNOWN};
  int fail_count, num_checks, ntx, n0, sd, seed = 32'h21564639;
  logic [16:0] fq[$];
  logic [16:0] ef;
  logic [13:0] tq[$];
  logic [31:0] rq[$];
  assign hready = hreadyout;
  // Short refill period keeps the bucket tests within twenty thousand cycles.
  port_rate_storm_priority #(.REFILL_CYC(40)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rx_valid, .rx_ready,
    .rx_len, .rx_kind, .rx_tagged, .rx_prio, .fwd_valid, .fwd_ready, .fwd_len, .fwd_prio,
    .eg_valid, .eg_ready, .eg_len, .tx_valid, .tx_ready, .tx_len);
  fabric_model u_fab (.clk(hclk), .rst_n(hresetn), .mode(pmode), .fwd_ready, .tx_ready);
  // ==========================================================================
  // Clock, watchdog and verdict.
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial
  begin
    repeat (40000) @(posedge hclk);
    fail_count++;
    final_report();
  end
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Result watcher: each result takes the oldest note of its kind.
  always @(posedge hclk)
  begin
    // Notes are popped once into locals, since the macro names its arguments twice.
    if (rph === 1'b1)
    begin
      er = rq.pop_front();
      `CHK(hrdata, er)
    end
    rph <= hsel && htrans[1] && !hwrite && hready;
    if (fwd_valid === 1'b1 && fwd_ready === 1'b1)
    begin
      ef = fq.pop_front();
      `CHK({fwd_len, fwd_prio}, ef)
    end
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      ntx++;
      et = tq.pop_front();
      `CHK(tx_len, et)
    end
  end
  // ==========================================================================
  // Drivers; each is entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    rd(a, e);
  endtask : wrc
  task automatic ctl(input logic rxu, input logic txu, input logic sen, input logic [1:0] ty);
    wrc(CTRL_OFF, {21'h0, dp, 2'h0, ty, 1'b0, sen, txu, rxu},
        {21'h0, dp, 2'h0, ty, 1'b0, sen, txu, rxu});
  endtask : ctl
  task automatic rxf(input logic [13:0] l, input frame_kind_t k, input logic t,
                     input logic [2:0] p, input logic pass);
    rx_valid <= 1'b1; rx_len <= l; rx_kind <= k; rx_tagged <= t; rx_prio <= p;
    do @(posedge hclk); while (rx_ready !== 1'b1);
    if (pass) fq.push_back({l, t ? p : dp});
  endtask : rxf
  task automatic egf(input logic [13:0] l);
    eg_valid <= 1'b1; eg_len <= l;
    do @(posedge hclk); while (eg_ready !== 1'b1);
    tq.push_back(l);
  endtask : egf
  task automatic drain;
    while (fq.size() + tq.size() > 0) @(posedge hclk);
  endtask : drain
  function automatic logic [13:0] rlen;
    return 14'(32'h40 + ($unsigned($random(seed)) % 32'h5AF));
  endfunction : rlen
  // ==========================================================================
  // Main sequence.
  initial
  begin
    {hsel, hwrite, rx_valid, rx_tagged, eg_valid, rph, dp} = '0;
    haddr = '0; hwdata = '0; htrans = '0; hsize = 3'h2; rx_len = '0; rx_prio = '0;
    rx_kind = KIND_UNICAST; eg_len = '0; pmode = 2'h1; hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CTRL_OFF, 32'h3);
    rd(RX_RATE_OFF, {12'h0, RX_RATE_MIN});
    rd(TX_RATE_OFF, {12'h0, TX_RATE_MIN});
    rd(STORM_THR_OFF, 32'hDAC);
    rd(8'h1C, 32'h0);
    // Every default priority, untagged frames of any class and tagged broadcast frames.
    for (int p = 0; p < 8; p++)
    begin
      dp = 3'(p);
      ctl(1'b1, 1'b1, 1'b0, STORM_B);
      rxf(rlen(), frame_kind_t'(2'($random(seed))), 1'b0, 3'h0, 1'b1);
      rxf(rlen(), KIND_BCAST, 1'b1, 3'($random(seed)), 1'b1);
      rx_valid <= 1'b0;
      drain();
    end
    wrc(RX_RATE_OFF, 32'h64, 32'hDAC);
    wrc(TX_RATE_OFF, 32'h0, 32'h40);
    wrc(STORM_THR_OFF, 32'hFFFFF, 32'hF4240);
    wrc(STORM_THR_OFF, 32'hDAC, 32'hDAC);
    // Each storm selection: the first policed frame fits the full bucket only.
    pmode <= 2'h0;
    sd = 0;
    for (int t = 0; t < 3; t++)
    begin
      ctl(1'b1, 1'b1, 1'b1, 2'(t));
      repeat (400) @(posedge hclk);
      used = 1'b0;
      for (int i = 0; i < 7; i++)
      begin
        pc = ks[i] == KIND_BCAST || (t > 0 && ks[i] == KIND_MCAST) ||
             (t == 2 && ks[i] == KIND_UNKNOWN);
        rxf(14'h5EE, ks[i], 1'b0, 3'h0, !(pc && used));
        if (pc && used) sd++;
        if (pc) used = 1'b1;
      end
      rx_valid <= 1'b0;
      drain();
      rd(STORM_DROP_OFF, 32'(sd));
    end
    // Ingress limit at the minimum rate: one full frame passes, two drop.
    ctl(1'b0, 1'b1, 1'b0, STORM_B);
    repeat (400) @(posedge hclk);
    rxf(14'h5EE, KIND_UNICAST, 1'b0, 3'h0, 1'b1);
    rxf(14'h5EE, KIND_UNICAST, 1'b0, 3'h0, 1'b0);
    rxf(14'h5EE, KIND_UNICAST, 1'b0, 3'h0, 1'b0);
    rx_valid <= 1'b0;
    drain();
    rd(RX_DROP_OFF, 32'h2);
    // Egress queue filled while the link stalls, then drained.
    ctl(1'b1, 1'b1, 1'b0, STORM_B);
    pmode <= 2'h2;
    eg_valid <= 1'b1;
    eg_len <= rlen();
    repeat (12)
    begin
      @(posedge hclk);
      if (eg_ready === 1'b1)
      begin
        tq.push_back(eg_len);
        eg_len <= rlen();
      end
    end
    eg_valid <= 1'b0;
    rd(LEVEL_OFF, 32'h8);
    pmode <= 2'h1;
    drain();
    rd(LEVEL_OFF, 32'h0);
    // Egress limit at 64 kbps: the second full frame waits for tokens.
    ctl(1'b1, 1'b0, 1'b0, STORM_B);
    repeat (8000) @(posedge hclk);
    pmode <= 2'h0;
    n0 = ntx;
    egf(14'h5EE);
    egf(14'h5EE);
    eg_valid <= 1'b0;
    repeat (1000) @(posedge hclk);
    `CHK(ntx, n0 + 1)
    drain();
    final_report();
  end
endmodule : port_rate_storm_priority_tb_top
`default_nettype wire
